// ===== clk_switch_regs.vh
// Register map, field positions and timing counts of the clock switch
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone bus
`ifndef CLK_SWITCH_REGS_VH
`define CLK_SWITCH_REGS_VH

// Register byte offsets
`define OSC_CONTROL_OFS   8'h00
`define TIMER_ONE_OFS     8'h04
`define INT_SRC_OFS       8'h08
`define MODE_STATUS_OFS   8'h0c

// Oscillator control register fields
`define IDLE_SELECT_BIT   7
`define FREQ_SEL_HI       6
`define FREQ_SEL_LO       4
`define PRI_FLAG_BIT      3
`define INT_STABLE_BIT    2
`define SRC_SEL_HI        1
`define SRC_SEL_LO        0

// Timer one control register fields
`define SECONDARY_RUN_MODE_FLAG_BIT  6
`define SEC_OSC_EN_BIT    3

// Internal source register field
`define INT_SRC_SEL_BIT   7

// Reset values
`define IDLE_SELECT_RST   1'b0
`define FREQ_SEL_RST      3'h0
`define SRC_SEL_RST       2'h0
`define SEC_OSC_EN_RST    1'b0
`define INT_SRC_SEL_RST   1'b0

// Clock source codes
`define SRC_PRI           2'h0
`define SRC_SEC           2'h1
`define SRC_INT           2'h2

// Switch lengths in source cycles
`define OLD_SRC_CYCLES    2'h2
`define NEW_SRC_CYCLES    2'h3

// Internal oscillator settle interval
`define CLK_MHZ           125
`define SETTLE_NS         1000
`define SETTLE_CYC        ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== clk_switch.v
// Power mode and clock source switch with a classic Wishbone slave
// Assumes oscillator levels and ready pins arrive asynchronously;
// sleep and wake pulses come from the core on clk_i
//
// What this block does
// - A switch takes two old-source cycles plus three to four new-source cycles
// - Primary flag at bit 3, stable flag bit 2, secondary flag bit 6
// - Each flag tells which source is driving the device clock
// - No flag set means low-frequency RC or unsettled internal clock
// - Internal block as primary may show both primary and stable flags
// - Each sleep uses the idle-select value present at that moment
// - After reset start in primary run with primary flag, unless two-speed
// - Select 01 moves to secondary, stops primary, sets secondary flag
// - Select 01 with secondary oscillator disabled leaves the mode unchanged
// - Secondary enabled but not started holds device clocks off
// - Back to primary keeps secondary clock until primary ready
// - Upper select bit set enters internal run, stops primary
// - Internal frequency field may change any time, speed follows at once
// - Frequency field and source bit zero keep internal output off
// - Stable flag set only after the settle interval, clocks keep running
// - Stable flag stays set if internal output was already settled
// - Back from internal run waits for primary, then swaps flags
// - Low-frequency RC runs while watchdog or clock monitor enabled
// - Sleep with idle clear stops the source and clears all flags
// - In sleep, RC runs for the watchdog, secondary runs if enabled
// - Wake from sleep waits for source or runs from internal block
// - Idle-select bit 7; idle stops the core, peripherals stay clocked
// - Select bits 1:0: 00 primary, 01 secondary, 1x internal
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "clk_switch_regs.vh"

module clk_switch (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        sleep_i,
	input  wire        wake_i,
	input  wire        pri_osc_i,
	input  wire        sec_osc_i,
	input  wire        int_osc_i,
	input  wire        pri_ready_i,
	input  wire        sec_started_i,
	input  wire        two_speed_en_i,
	input  wire        fail_safe_en_i,
	input  wire        watchdog_en_i,
	input  wire        pri_is_internal_i,
	output reg         cpu_clk_en_o,
	output reg         periph_clk_en_o,
	output reg         pri_osc_en_o,
	output reg         sec_osc_en_o,
	output reg         int_hf_en_o,
	output reg  [2:0]  int_freq_o,
	output reg         lfrc_en_o,
	output reg  [2:0]  mode_o
);

////////////////////////////////////////////////////////////////////////
// Mode states
localparam [2:0] ST_BOOT  = 3'h0;
localparam [2:0] ST_RUN   = 3'h1;
localparam [2:0] ST_SWOLD = 3'h2;
localparam [2:0] ST_SWNEW = 3'h3;
localparam [2:0] ST_WAIT  = 3'h4;
localparam [2:0] ST_IDLE  = 3'h5;
localparam [2:0] ST_SLEEP = 3'h6;

// Software state
reg        idle_select_bit_r;
reg  [2:0] internal_freq_select_field_r;
reg  [1:0] clock_source_select_field_r;
reg        secondary_osc_enable_bit_r;
reg        internal_source_select_bit_r;

// Status flags
reg        primary_clock_active_flag_r;
reg        internal_osc_stable_flag_r;
reg        secondary_osc_running_flag_r;

// Mode machine
reg  [2:0] state_r;
reg  [2:0] state_nxt;
reg  [1:0] cur_src_r;
reg  [1:0] cur_src_nxt;
reg  [1:0] new_src_r;
reg  [1:0] new_src_nxt;
reg  [1:0] cyc_cnt_r;
reg  [1:0] cyc_cnt_nxt;
reg  [11:0] settle_cnt_r;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers, unreset so the boot state sees real straps;
// osc levels get a third stage for edges
reg  [8:0] sync1_r;
reg  [8:0] sync2_r;
reg  [2:0] osc_prev_r;
wire [8:0] pins_in;

assign pins_in = {pri_is_internal_i, watchdog_en_i, fail_safe_en_i,
	two_speed_en_i, sec_started_i, pri_ready_i,
	int_osc_i, sec_osc_i, pri_osc_i};

always @(posedge clk_i) begin
	sync1_r    <= pins_in;
	sync2_r    <= sync1_r;
	osc_prev_r <= sync2_r[2:0];
end

wire       pri_ready_s   = sync2_r[3];
wire       sec_started_s = sync2_r[4];
wire       two_speed_s   = sync2_r[5];
wire       fail_safe_s   = sync2_r[6];
wire       watchdog_s    = sync2_r[7];
wire       pri_is_int_s  = sync2_r[8];
// One tick per rising edge of each source
wire [2:0] osc_tick      = sync2_r[2:0] & ~osc_prev_r;

////////////////////////////////////////////////////////////////////////
// Source helpers, shared by the machine and the gating
function tick_of;
	input [1:0] src;
	input [2:0] ticks;
	begin
		case (src)
			`SRC_PRI: tick_of = ticks[0];
			`SRC_SEC: tick_of = ticks[1];
			default:  tick_of = ticks[2];
		endcase
	end
endfunction

function ready_of;
	input [1:0] src;
	input       pri_rdy;
	input       sec_rdy;
	begin
		case (src)
			`SRC_PRI: ready_of = pri_rdy;
			`SRC_SEC: ready_of = sec_rdy;
			default:  ready_of = 1'b1;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Wanted source from the select field
reg  [1:0] tgt_src;
wire       hf_req = (internal_freq_select_field_r != 3'h0) |
	internal_source_select_bit_r;

always @* begin
	if (clock_source_select_field_r[1])
		tgt_src = `SRC_INT;
	else if (clock_source_select_field_r[0])
		tgt_src = secondary_osc_enable_bit_r ? `SRC_SEC : cur_src_r;
	else
		tgt_src = `SRC_PRI;
end

wire tgt_ready = ready_of(tgt_src, pri_ready_s, sec_started_s);
wire new_ready = ready_of(new_src_r, pri_ready_s, sec_started_s);
wire old_tick  = tick_of(cur_src_r, osc_tick);
wire new_tick  = tick_of(new_src_r, osc_tick);

////////////////////////////////////////////////////////////////////////
// Mode machine
always @* begin
	state_nxt   = state_r;
	cur_src_nxt = cur_src_r;
	new_src_nxt = new_src_r;
	cyc_cnt_nxt = cyc_cnt_r;
	case (state_r)
		ST_BOOT: begin
			if (two_speed_s) begin
				cur_src_nxt = `SRC_INT;
				state_nxt   = ST_RUN;
			end else begin
				cur_src_nxt = `SRC_PRI;
				new_src_nxt = `SRC_PRI;
				state_nxt   = ST_WAIT;
			end
		end
		ST_RUN: begin
			if (sleep_i) begin
				// Idle bit sampled at each sleep pulse
				state_nxt = idle_select_bit_r ? ST_IDLE : ST_SLEEP;
			end else if (tgt_src != cur_src_r) begin
				new_src_nxt = tgt_src;
				cyc_cnt_nxt = 2'h0;
				if (tgt_ready)
					state_nxt = ST_SWOLD;
				else if (tgt_src == `SRC_SEC)
					state_nxt = ST_WAIT;
				// Primary still starting: old source keeps clocking
			end
		end
		ST_SWOLD: begin
			if (old_tick) begin
				if (cyc_cnt_r == `OLD_SRC_CYCLES - 2'h1) begin
					cyc_cnt_nxt = 2'h0;
					state_nxt   = ST_SWNEW;
				end else begin
					cyc_cnt_nxt = cyc_cnt_r + 2'h1;
				end
			end
		end
		ST_SWNEW: begin
			// Sync lag on the new source makes this three to four cycles
			if (new_tick) begin
				if (cyc_cnt_r == `NEW_SRC_CYCLES - 2'h1) begin
					cyc_cnt_nxt = 2'h0;
					cur_src_nxt = new_src_r;
					state_nxt   = ST_RUN;
				end else begin
					cyc_cnt_nxt = cyc_cnt_r + 2'h1;
				end
			end
		end
		ST_WAIT: begin
			// Clocks held off; no old source to hand over from
			if (new_ready) begin
				cur_src_nxt = new_src_r;
				state_nxt   = ST_RUN;
			end
		end
		ST_IDLE: begin
			if (wake_i)
				state_nxt = ST_RUN;
		end
		ST_SLEEP: begin
			if (wake_i) begin
				if (two_speed_s | fail_safe_s) begin
					cur_src_nxt = `SRC_INT;
					state_nxt   = ST_RUN;
				end else begin
					new_src_nxt = tgt_src;
					state_nxt   = ST_WAIT;
				end
			end
		end
		default: begin
			state_nxt = ST_BOOT;
		end
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		state_r   <= ST_BOOT;
		cur_src_r <= `SRC_PRI;
		new_src_r <= `SRC_PRI;
		cyc_cnt_r <= 2'h0;
	end else begin
		state_r   <= state_nxt;
		cur_src_r <= cur_src_nxt;
		new_src_r <= new_src_nxt;
		cyc_cnt_r <= cyc_cnt_nxt;
	end
end

////////////////////////////////////////////////////////////////////////
// Internal oscillator settle timer; restarts only from all-zero
always @(posedge clk_i) begin
	if (rst_i)
		settle_cnt_r <= 12'h000;
	else if (!int_hf_en_o)
		settle_cnt_r <= 12'h000;
	else if (settle_cnt_r != `SETTLE_CYC)
		settle_cnt_r <= settle_cnt_r + 12'h001;
end

wire settled = int_hf_en_o && (settle_cnt_r == `SETTLE_CYC);

////////////////////////////////////////////////////////////////////////
// Status flags; held through a switch, cleared in sleep
wire run_like = (state_r == ST_RUN) || (state_r == ST_IDLE);

always @(posedge clk_i) begin
	if (rst_i || state_r == ST_BOOT || state_r == ST_SLEEP) begin
		primary_clock_active_flag_r  <= 1'b0;
		internal_osc_stable_flag_r   <= 1'b0;
		secondary_osc_running_flag_r <= 1'b0;
	end else if (run_like) begin
		primary_clock_active_flag_r  <= cur_src_r == `SRC_PRI;
		secondary_osc_running_flag_r <= cur_src_r == `SRC_SEC;
		// Stable flag only with a settled output driving the clock
		internal_osc_stable_flag_r <= settled && ((cur_src_r == `SRC_INT) ||
			(cur_src_r == `SRC_PRI && pri_is_int_s));
	end else if (state_r == ST_WAIT) begin
		primary_clock_active_flag_r  <= 1'b0;
		internal_osc_stable_flag_r   <= 1'b0;
		secondary_osc_running_flag_r <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// Clock gating and oscillator enables
// Core and peripheral enables pulse only after source ticks, so no pulse is ever cut short
always @(posedge clk_i) begin
	if (rst_i) begin
		cpu_clk_en_o    <= 1'b0;
		periph_clk_en_o <= 1'b0;
		pri_osc_en_o    <= 1'b1;
		sec_osc_en_o    <= 1'b0;
		int_hf_en_o     <= 1'b0;
		int_freq_o      <= 3'h0;
		lfrc_en_o       <= 1'b0;
		mode_o          <= 3'h0;
	end else begin
		cpu_clk_en_o    <= (state_r == ST_RUN) && old_tick;
		periph_clk_en_o <= run_like && old_tick;
		pri_osc_en_o    <= (state_r != ST_SLEEP) &&
			(cur_src_r == `SRC_PRI || tgt_src == `SRC_PRI);
		sec_osc_en_o    <= secondary_osc_enable_bit_r;
		int_hf_en_o     <= hf_req && (state_r != ST_SLEEP);
		int_freq_o      <= internal_freq_select_field_r;
		lfrc_en_o       <= watchdog_s | fail_safe_s | ((state_r != ST_SLEEP) &&
			cur_src_r == `SRC_INT && !hf_req);
		mode_o          <= state_r;
	end
end

////////////////////////////////////////////////////////////////////////
// Wishbone slave: ack one cycle after the strobe, dropped after one
wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

always @(posedge clk_i) begin
	if (rst_i)
		wb_ack_o <= 1'b0;
	else
		wb_ack_o <= wb_req;
end

// Register writes; flag bits are read only
always @(posedge clk_i) begin
	if (rst_i) begin
		idle_select_bit_r            <= `IDLE_SELECT_RST;
		internal_freq_select_field_r <= `FREQ_SEL_RST;
		clock_source_select_field_r  <= `SRC_SEL_RST;
		secondary_osc_enable_bit_r   <= `SEC_OSC_EN_RST;
		internal_source_select_bit_r <= `INT_SRC_SEL_RST;
	end else if (wb_wr) begin
		case (wb_adr_i)
			`OSC_CONTROL_OFS: begin
				idle_select_bit_r <= wb_dat_i[`IDLE_SELECT_BIT];
				internal_freq_select_field_r <=
					wb_dat_i[`FREQ_SEL_HI:`FREQ_SEL_LO];
				clock_source_select_field_r <=
					wb_dat_i[`SRC_SEL_HI:`SRC_SEL_LO];
			end
			`TIMER_ONE_OFS: begin
				secondary_osc_enable_bit_r <= wb_dat_i[`SEC_OSC_EN_BIT];
			end
			`INT_SRC_OFS: begin
				internal_source_select_bit_r <= wb_dat_i[`INT_SRC_SEL_BIT];
			end
			default: begin
				idle_select_bit_r <= idle_select_bit_r;
			end
		endcase
	end
end

// Read data; unmapped addresses read zero
always @(posedge clk_i) begin
	if (rst_i) begin
		wb_dat_o <= 32'h00000000;
	end else if (wb_req) begin
		wb_dat_o <= 32'h00000000;
		case (wb_adr_i)
			`OSC_CONTROL_OFS: begin
				wb_dat_o[`IDLE_SELECT_BIT] <= idle_select_bit_r;
				wb_dat_o[`FREQ_SEL_HI:`FREQ_SEL_LO] <=
					internal_freq_select_field_r;
				wb_dat_o[`PRI_FLAG_BIT]   <= primary_clock_active_flag_r;
				wb_dat_o[`INT_STABLE_BIT] <= internal_osc_stable_flag_r;
				wb_dat_o[`SRC_SEL_HI:`SRC_SEL_LO] <= clock_source_select_field_r;
			end
			`TIMER_ONE_OFS: begin
				wb_dat_o[`SECONDARY_RUN_MODE_FLAG_BIT] <= secondary_osc_running_flag_r;
				wb_dat_o[`SEC_OSC_EN_BIT]   <= secondary_osc_enable_bit_r;
			end
			`INT_SRC_OFS: begin
				wb_dat_o[`INT_SRC_SEL_BIT] <= internal_source_select_bit_r;
			end
			`MODE_STATUS_OFS: begin
				wb_dat_o[2:0] <= state_r;
				wb_dat_o[5:4] <= cur_src_r;
			end
			default: begin
				wb_dat_o <= 32'h00000000;
			end
		endcase
	end
end

endmodule

// ===== clk_switch_properties.sv
// Concurrent checks on the clock switch top-level ports
// Assumes binding onto clk_switch; one clock, synchronous active-high reset
`timescale 1ns/1ns
module clk_switch_properties (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       sleep_i,
	input wire logic       cpu_clk_en_o,
	input wire logic       periph_clk_en_o,
	input wire logic       pri_osc_en_o,
	input wire logic [2:0] mode_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Bus answer, reset state
	property p_ack;
		@(posedge clk_i) disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
	property p_rst;
		@(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> mode_o == 3'h0 && pri_osc_en_o && !cpu_clk_en_o;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state out of reset");
	////////////////////////////////////////////////////////////////////////////////
	// Sleep and idle; state is seen one cycle late on mode_o
	property p_sleep;
		@(posedge clk_i) disable iff (rst_i)
		(sleep_i && mode_o == 3'h1) ##1 (mode_o == 3'h1) |=> (mode_o == 3'h5 || mode_o == 3'h6);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep pulse in run not taken");
	property p_sleep_out;
		@(posedge clk_i) disable iff (rst_i) mode_o == 3'h6 |-> !cpu_clk_en_o && !periph_clk_en_o && !pri_osc_en_o;
	endproperty
	a_sleep_out: assert property (p_sleep_out) else $error("clocks alive in sleep");
	property p_idle;
		@(posedge clk_i) disable iff (rst_i) mode_o == 3'h5 |-> !cpu_clk_en_o;
	endproperty
	a_idle: assert property (p_idle) else $error("core clocked in idle");
	property p_cpu_run;
		@(posedge clk_i) disable iff (rst_i) cpu_clk_en_o |-> periph_clk_en_o && mode_o == 3'h1;
	endproperty
	a_cpu_run: assert property (p_cpu_run) else $error("core tick outside run");
	////////////////////////////////////////////////////////////////////////////////
	// Switching phases: no ticks escape, old phase then a new phase of at least three cycles
	property p_hold;
		@(posedge clk_i) disable iff (rst_i) mode_o inside {3'h2, 3'h3, 3'h4} |-> !periph_clk_en_o;
	endproperty
	a_hold: assert property (p_hold) else $error("tick during switch or wait");
	property p_old_new;
		@(posedge clk_i) disable iff (rst_i) mode_o == 3'h2 ##1 mode_o != 3'h2 |-> mode_o == 3'h3;
	endproperty
	a_old_new: assert property (p_old_new) else $error("old phase not followed by new phase");
	property p_new_len;
		@(posedge clk_i) disable iff (rst_i) $rose(mode_o == 3'h3) |-> (mode_o == 3'h3) [*3];
	endproperty
	a_new_len: assert property (p_new_len) else $error("new phase too short");
endmodule
bind clk_switch clk_switch_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .cpu_clk_en_o(cpu_clk_en_o),
	.periph_clk_en_o(periph_clk_en_o), .pri_osc_en_o(pri_osc_en_o), .mode_o(mode_o));

// ===== osc_partner.sv
// Behavioural oscillators and their start-up indications
// Assumes enables come from the clock switch; lines stand at 0 when stopped
`timescale 1ns/1ns
module osc_partner (
	input  wire logic clk_i,
	input  wire logic pri_en_i,
	input  wire logic sec_en_i,
	output logic      pri_osc_o,
	output logic      sec_osc_o,
	output logic      int_osc_o,
	output logic      pri_ready_o,
	output logic      sec_started_o
);
	int pri_cnt;
	int sec_cnt;
	// Free-running internal oscillator, gated external sources
	initial begin
		pri_osc_o = 1'b0;
		sec_osc_o = 1'b0;
		int_osc_o = 1'b0;
		pri_cnt = 0;
		sec_cnt = 0;
		pri_ready_o = 1'b0;
		sec_started_o = 1'b0;
	end
	always #32 pri_osc_o = pri_en_i ? ~pri_osc_o : 1'b0;
	always #80 sec_osc_o = sec_en_i ? ~sec_osc_o : 1'b0;
	always #48 int_osc_o = ~int_osc_o;
	// Start-up delays; readiness drops at once when disabled, never kinder
	always @(posedge clk_i) begin
		pri_cnt <= pri_en_i ? ((pri_cnt == 40) ? 40 : pri_cnt + 1) : 0;
		sec_cnt <= sec_en_i ? ((sec_cnt == 60) ? 60 : sec_cnt + 1) : 0;
		pri_ready_o <= (pri_cnt == 40);
		sec_started_o <= (sec_cnt == 60);
	end
endmodule

// ===== power_mode_clock_switch_tb_top.sv
// Self-checking bench for the clock switch: bus reads checked through a queue
// Assumes the oscillator partner model and the bound property checker
`timescale 1ns/1ns
`include "clk_switch_regs.vh"
module power_mode_clock_switch_tb_top;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_i, wake_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, exp_q[$], lo, seed;
	logic        pri_osc, sec_osc, int_osc, pri_rdy, sec_st, wdog, tspeed, fsafe, pri_int;
	logic        cpu_en, per_en, pri_en, sec_en, hf_en, lfrc_en;
	logic [2:0]  int_freq, mode_o;
	int          error_cnt, n_tests, k;
	clk_switch i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .wake_i(wake_i),
		.pri_osc_i(pri_osc), .sec_osc_i(sec_osc), .int_osc_i(int_osc), .pri_ready_i(pri_rdy),
		.sec_started_i(sec_st), .two_speed_en_i(tspeed), .fail_safe_en_i(fsafe),
		.watchdog_en_i(wdog), .pri_is_internal_i(pri_int), .cpu_clk_en_o(cpu_en),
		.periph_clk_en_o(per_en), .pri_osc_en_o(pri_en), .sec_osc_en_o(sec_en),
		.int_hf_en_o(hf_en), .int_freq_o(int_freq), .lfrc_en_o(lfrc_en), .mode_o(mode_o));
	osc_partner i_osc (.clk_i(clk_i), .pri_en_i(pri_en), .sec_en_i(sec_en), .pri_osc_o(pri_osc),
		.sec_osc_o(sec_osc), .int_osc_o(int_osc), .pri_ready_o(pri_rdy), .sec_started_o(sec_st));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, comparison, verdict
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Read data taken at the ack edge, oldest note first
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			check("read data", wb_dat_o, exp_q.pop_front());
	end
	////////////////////////////////////////////////////////////////////////////////
	// Bus cycle and bounded waits
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= we ? d : 32'h0;
		if (!we) exp_q.push_back(d);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			complete_run;
		end
	endtask
	task wait_mode(input logic [2:0] m, input logic eq);
		int n;
		n = 0;
		while (((mode_o === m) != eq) && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 4000) begin
			error_cnt++;
			complete_run;
		end
	endtask
	// Leave run, come back, let flags settle
	task wait_sw;
		wait_mode(3'h1, 1'b0);
		wait_mode(3'h1, 1'b1);
		repeat (4) @(posedge clk_i);
	endtask
	task pulse(input logic slp);
		@(posedge clk_i);
		if (slp) sleep_i <= 1'b1;
		else wake_i <= 1'b1;
		@(posedge clk_i);
		sleep_i <= 1'b0;
		wake_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 32'hd27e5592;
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i, wake_i, tspeed, fsafe, pri_int} = 9'h100;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		error_cnt = 0;
		n_tests = 0;
		lo = $random(seed);
		wdog = lo[1];
		lo = lo & 32'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_mode(3'h1, 1'b1);
		repeat (4) @(posedge clk_i);
		wb(0, `OSC_CONTROL_OFS, 32'h08);
		wb(0, `TIMER_ONE_OFS, 32'h00);
		wb(0, 8'h10, 32'h00);
		wb(0, `MODE_STATUS_OFS, 32'h01);
		wb(1, `OSC_CONTROL_OFS, 32'h01);
		repeat (20) @(posedge clk_i);
		wb(0, `OSC_CONTROL_OFS, 32'h09);
		wb(1, `OSC_CONTROL_OFS, 32'h00);
		wb(1, `TIMER_ONE_OFS, 32'h08);
		wb(1, `OSC_CONTROL_OFS, 32'h01);
		wait_sw;
		wb(0, `OSC_CONTROL_OFS, 32'h01);
		wb(0, `TIMER_ONE_OFS, 32'h48);
		wb(0, `MODE_STATUS_OFS, 32'h11);
		check("pri enable", pri_en, 32'h0);
		wb(1, `OSC_CONTROL_OFS, 32'h00);
		wait_sw;
		wb(0, `OSC_CONTROL_OFS, 32'h08);
		wb(0, `TIMER_ONE_OFS, 32'h08);
		check("sec enable", sec_en, 32'h1);
		wb(1, `OSC_CONTROL_OFS, 32'h72 | lo);
		wait_sw;
		repeat (150) @(posedge clk_i);
		wb(0, `OSC_CONTROL_OFS, 32'h76 | lo);
		check("pri enable", pri_en, 32'h0);
		wb(1, `OSC_CONTROL_OFS, 32'h52 | lo);
		repeat (3) @(posedge clk_i);
		check("int freq", int_freq, 32'h5);
		wb(0, `OSC_CONTROL_OFS, 32'h56 | lo);
		wb(1, `OSC_CONTROL_OFS, 32'h50);
		wait_sw;
		wb(0, `OSC_CONTROL_OFS, 32'h58);
		wb(1, `OSC_CONTROL_OFS, 32'h00);
		repeat (4) @(posedge clk_i);
		check("hf enable", hf_en, 32'h0);
		// Sleep, idle, then sleep again: idle bit read at each pulse
		for (k = 0; k < 3; k++) begin
			wb(1, `OSC_CONTROL_OFS, (k == 1) ? 32'h80 : 32'h00);
			pulse(1'b1);
			check("mode", mode_o, (k == 1) ? 32'h5 : 32'h6);
			wb(0, `OSC_CONTROL_OFS, (k == 1) ? 32'h88 : 32'h00);
			check("sec enable", sec_en, 32'h1);
			if (wdog) check("rc enable", lfrc_en, 32'h1);
			pulse(1'b0);
			wait_mode(3'h1, 1'b1);
			repeat (4) @(posedge clk_i);
			wb(0, `OSC_CONTROL_OFS, (k == 1) ? 32'h88 : 32'h08);
		end
		// Fail-safe wake runs from the internal block; then both flags in primary
		fsafe <= 1'b1;
		pri_int <= 1'b1;
		pulse(1'b1);
		pulse(1'b0);
		wb(0, `MODE_STATUS_OFS, 32'h21);
		check("rc enable", lfrc_en, 32'h1);
		wait_sw;
		wb(1, `OSC_CONTROL_OFS, 32'h70);
		repeat (150) @(posedge clk_i);
		wb(0, `OSC_CONTROL_OFS, 32'h7c);
		// Mid-run reset with two-speed start: boots on internal, then switches
		tspeed <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_mode(3'h2, 1'b1);
		wait_mode(3'h1, 1'b1);
		repeat (4) @(posedge clk_i);
		wb(0, `MODE_STATUS_OFS, 32'h01);
		// Let the last read be compared before the verdict
		@(posedge clk_i);
		if (exp_q.size() != 0) error_cnt++;
		complete_run;
	end
endmodule
